// ==== common/cgsw_pkg.sv ====
// constants shared by the codegroup/slot width adapter and its elastic buffer
// assumes a link clock on its own port and a smoothed core clock clk_in
//
// Overview of operation
// - transmit shifts each 10-bit code group out one bit per link clock
// - receive gathers line bits into code groups; boundary moves only when enabled
// - eight 9-bit code groups pack into one slot word, and back again
// - receive slot grouping restarts when slot sync loss falls
// - transmit inserts inter-frame gap groups without dropping payload
// - receive strips gap groups and packs the rest contiguously while slot sync holds
// - received groups enter an elastic buffer, leave on the smoothed clock
// - buffer depth and prefill level keep phase wander from over or underflow
// - smoothed frame start follows incoming frame start with jitter removed
// - comma 1111100 with alignment enabled raises frame start flag, else low
// - slot sync lost is high exactly in the loss state
package cgsw_pkg;
   localparam int       CG_BITS        = 10;
   localparam int       CG_CNT_W       = 4;
   localparam logic [3:0] CG_LAST      = 4'h9;
   localparam logic [3:0] COMMA_NEXT   = 4'h7;
   localparam logic [6:0] COMMA_SEQ    = 7'h7c;
   localparam logic [9:0] TX_IDLE_CG   = 10'h0fa;
   localparam int       SG_W           = 9;
   localparam int       SLOT_GROUPS    = 8;
   localparam int       SLOT_W         = SG_W * SLOT_GROUPS;
   localparam int       IDX_W          = 3;
   localparam logic [2:0] IDX_LAST     = 3'h7;
   localparam logic [2:0] IDX_AFTER_FILL = 3'h1;
   localparam logic [8:0] FILL_GROUP   = 9'h1f0;
   localparam logic [8:0] GAP_GROUP    = 9'h1f1;
   localparam logic [7:0] SLOTS_PER_GAP = 8'h10;
   localparam logic [3:0] GAP_GROUPS   = 4'h2;
   localparam int       EB_AW          = 4;
   localparam int       EB_TX_PREFILL  = 1;
   localparam int       EB_RX_NOMINAL  = 8;
   localparam int       FS_W           = 16;
   localparam int       FRAME_PERIOD_DEFAULT = 6250;

   typedef enum logic [0:0] {
      CGSW_SYNC_LOSS = 1'b0,
      CGSW_SYNC_HELD = 1'b1
   } cgsw_sync_e;

   typedef enum logic [0:0] {
      CGSW_TX_SEND = 1'b0,
      CGSW_TX_GAP  = 1'b1
   } cgsw_tx_e;
endpackage

// ==== core/cgsw_elastic_buffer.sv ====
// dual-clock elastic buffer with gray-coded pointers
// assumes one shared asynchronous reset for both clock domains
module cgsw_elastic_buffer #(
   parameter int W       = 10,
   parameter int AW      = 4,
   parameter int PREFILL = 1
) (
   input  wire logic         reset_in,
   input  wire logic         wr_clk_in,
   input  wire logic         wr_valid_in,
   input  wire logic [W-1:0] wr_data_in,
   output logic              wr_ready_out,
   input  wire logic         rd_clk_in,
   input  wire logic         rd_ready_in,
   output logic              rd_valid_out,
   output logic [W-1:0]      rd_data_out
);
   localparam int DEPTH = 1 << AW;
   localparam logic [AW:0] PREFILL_LVL = (AW+1)'(PREFILL);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wbin_reg, wgray_reg, rq1_reg, rq2_reg;
   logic [AW:0]  rbin_reg, rgray_reg, wq1_reg, wq2_reg;
   logic         run_reg;

   function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
      logic [AW:0] b;
      b[AW] = g[AW];
      for (int i = AW - 1; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   wire         full      = wgray_reg == {~rq2_reg[AW:AW-1], rq2_reg[AW-2:0]};
   wire         push      = wr_valid_in && !full;
   wire [AW:0]  wbin_next = wbin_reg + 1'b1;
   assign wr_ready_out = !full;

   always_ff @(posedge wr_clk_in) begin
      if (push) begin
         mem[wbin_reg[AW-1:0]] <= wr_data_in;
      end
   end

   always_ff @(posedge wr_clk_in or posedge reset_in) begin
      if (reset_in) begin
         wbin_reg  <= '0;
         wgray_reg <= '0;
         rq1_reg   <= '0;
         rq2_reg   <= '0;
      end else begin
         rq1_reg <= rgray_reg;
         rq2_reg <= rq1_reg;
         if (push) begin
            wbin_reg  <= wbin_next;
            wgray_reg <= bin2gray(wbin_next);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   wire [AW:0] level     = gray2bin(wq2_reg) - rbin_reg;
   wire        pop       = rd_ready_in && rd_valid_out;
   wire [AW:0] rbin_next = rbin_reg + 1'b1;
   assign rd_valid_out = run_reg && (level != '0);
   assign rd_data_out  = mem[rbin_reg[AW-1:0]];

   always_ff @(posedge rd_clk_in or posedge reset_in) begin
      if (reset_in) begin
         rbin_reg  <= '0;
         rgray_reg <= '0;
         wq1_reg   <= '0;
         wq2_reg   <= '0;
         run_reg   <= 1'b0;
      end else begin
         wq1_reg <= wgray_reg;
         wq2_reg <= wq1_reg;
         // hold reads until nominal fill, re-center after running dry
         if (level == '0) begin
            run_reg <= 1'b0;
         end else if (level >= PREFILL_LVL) begin
            run_reg <= 1'b1;
         end
         if (pop) begin
            rbin_reg  <= rbin_next;
            rgray_reg <= bin2gray(rbin_next);
         end
      end
   end
endmodule

// ==== core/cgsw_adapter.sv ====
// codegroup/slot width adapter: serial link, code group and slot word paths
// assumes recovered_clock_in drives the line and clk_in is the smoothed clock
module cgsw_adapter
   import cgsw_pkg::*;
#(
   parameter int FRAME_PERIOD_CYCLES = cgsw_pkg::FRAME_PERIOD_DEFAULT
) (
   input  wire logic                       clk_in,
   input  wire logic                       reset_in,
   input  wire logic                       recovered_clock_in,
   input  wire logic                       serial_line_bits_in,
   output logic                            serial_line_bits_out,
   input  wire logic                       frame_align_enable_in,
   output logic                            frame_start_flag_out,
   input  wire logic [cgsw_pkg::CG_BITS-1:0] codegroup_parallel_data_in,
   input  wire logic                       codegroup_parallel_valid_in,
   output logic                            codegroup_parallel_ready_out,
   output logic [cgsw_pkg::CG_BITS-1:0]    codegroup_parallel_data_out,
   output logic                            codegroup_parallel_valid_out,
   input  wire logic [cgsw_pkg::SLOT_W-1:0] tx_slot_word_in,
   input  wire logic                       tx_slot_valid_in,
   output logic                            tx_slot_ready_out,
   output logic [cgsw_pkg::SG_W-1:0]       slot_codegroup_data_out,
   output logic                            slot_codegroup_valid_out,
   input  wire logic                       slot_codegroup_ready_in,
   input  wire logic [cgsw_pkg::SG_W-1:0]  slot_codegroup_data_in,
   input  wire logic                       slot_codegroup_valid_in,
   output logic [cgsw_pkg::SLOT_W-1:0]     rx_slot_word_out,
   output logic                            rx_slot_valid_out,
   output logic                            slot_sync_lost_out,
   input  wire logic                       incoming_frame_start_in,
   output logic                            smoothed_frame_start_out
);
   import cgsw_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // link domain: deserialiser and comma search
   logic [CG_BITS-1:0]  rx_sh_reg;
   logic [CG_CNT_W-1:0] rx_cnt_reg, rx_cnt_next;
   logic                en_q1_reg, en_q2_reg;
   logic                rx_word_valid_reg;
   logic [CG_BITS-1:0]  rx_word_reg;

   wire [6:0] comma_window = {rx_sh_reg[5:0], serial_line_bits_in};
   // comma seen in the latest seven bits
   wire       comma_hit    = comma_window == COMMA_SEQ;
   wire       align_now    = comma_hit && en_q2_reg;
   wire       rx_word_done = rx_cnt_reg == CG_LAST;

   always_comb begin
      rx_cnt_next = rx_cnt_reg + 1'b1;
      // word boundary moves only while alignment is enabled
      if (align_now) begin
         rx_cnt_next = COMMA_NEXT;
      end else if (rx_word_done) begin
         rx_cnt_next = '0;
      end
   end

   always_ff @(posedge recovered_clock_in or posedge reset_in) begin
      if (reset_in) begin
         rx_sh_reg            <= '0;
         rx_cnt_reg           <= '0;
         en_q1_reg            <= 1'b0;
         en_q2_reg            <= 1'b0;
         rx_word_reg          <= '0;
         rx_word_valid_reg    <= 1'b0;
         frame_start_flag_out <= 1'b0;
      end else begin
         en_q1_reg <= frame_align_enable_in;
         en_q2_reg <= en_q1_reg;
         rx_sh_reg  <= {rx_sh_reg[CG_BITS-2:0], serial_line_bits_in};
         rx_cnt_reg <= rx_cnt_next;
         rx_word_valid_reg <= rx_word_done && !align_now;
         if (rx_word_done) begin
            rx_word_reg <= {rx_sh_reg[CG_BITS-2:0], serial_line_bits_in};
         end
         // flag only when comma and enable coincide
         frame_start_flag_out <= align_now;
      end
   end

   // received groups written at line rate, read on the smoothed clock
   cgsw_elastic_buffer #(
      .W       (CG_BITS),
      .AW      (EB_AW),
      .PREFILL (EB_RX_NOMINAL)
   ) u_rx_buffer (
      .reset_in     (reset_in),
      .wr_clk_in    (recovered_clock_in),
      .wr_valid_in  (rx_word_valid_reg),
      .wr_data_in   (rx_word_reg),
      .wr_ready_out (),
      .rd_clk_in    (clk_in),
      .rd_ready_in  (1'b1),
      .rd_valid_out (codegroup_parallel_valid_out),
      .rd_data_out  (codegroup_parallel_data_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // transmit code groups cross to the link domain and are serialised
   logic               txf_valid;
   logic [CG_BITS-1:0] txf_data;
   logic [CG_BITS-1:0] tx_sh_reg;
   logic [CG_CNT_W-1:0] tx_cnt_reg;

   wire tx_load = tx_cnt_reg == CG_LAST;

   cgsw_elastic_buffer #(
      .W       (CG_BITS),
      .AW      (EB_AW),
      .PREFILL (EB_TX_PREFILL)
   ) u_tx_buffer (
      .reset_in     (reset_in),
      .wr_clk_in    (clk_in),
      .wr_valid_in  (codegroup_parallel_valid_in),
      .wr_data_in   (codegroup_parallel_data_in),
      .wr_ready_out (codegroup_parallel_ready_out),
      .rd_clk_in    (recovered_clock_in),
      .rd_ready_in  (tx_load),
      .rd_valid_out (txf_valid),
      .rd_data_out  (txf_data)
   );

   assign serial_line_bits_out = tx_sh_reg[CG_BITS-1];

   always_ff @(posedge recovered_clock_in or posedge reset_in) begin
      if (reset_in) begin
         tx_sh_reg  <= TX_IDLE_CG;
         tx_cnt_reg <= '0;
      end else if (tx_load) begin
         // next group loads after the tenth bit, idle if none waits
         tx_sh_reg  <= txf_valid ? txf_data : TX_IDLE_CG;
         tx_cnt_reg <= '0;
      end else begin
         tx_sh_reg  <= {tx_sh_reg[CG_BITS-2:0], 1'b0};
         tx_cnt_reg <= tx_cnt_reg + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit slot words unpack into code groups with periodic gaps
   cgsw_tx_e            tx_st_reg;
   logic [SLOT_W-1:0]   tx_word_reg;
   logic                tx_have_reg;
   logic [IDX_W-1:0]    tx_idx_reg;
   logic [7:0]          tx_slots_reg;
   logic [3:0]          tx_gap_reg;

   wire in_gap     = tx_st_reg == CGSW_TX_GAP;
   wire tx_fire    = slot_codegroup_valid_out && slot_codegroup_ready_in;
   wire slot_last  = tx_idx_reg == IDX_LAST;
   wire frame_last = tx_slots_reg == SLOTS_PER_GAP - 8'h01;
   wire gap_last   = tx_gap_reg == GAP_GROUPS - 4'h1;
   wire accept     = tx_slot_valid_in && tx_slot_ready_out;

   // no slot word taken during a gap
   assign tx_slot_ready_out        = !in_gap && !tx_have_reg;
   assign slot_codegroup_valid_out = in_gap || tx_have_reg;
   // gap group takes the line while payload waits
   assign slot_codegroup_data_out  = in_gap ? GAP_GROUP : tx_word_reg[tx_idx_reg*SG_W +: SG_W];

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         tx_st_reg    <= CGSW_TX_SEND;
         tx_word_reg  <= '0;
         tx_have_reg  <= 1'b0;
         tx_idx_reg   <= '0;
         tx_slots_reg <= '0;
         tx_gap_reg   <= '0;
      end else begin
         unique case (tx_st_reg)
            CGSW_TX_SEND: begin
               if (accept) begin
                  tx_word_reg <= tx_slot_word_in;
                  tx_have_reg <= 1'b1;
                  tx_idx_reg  <= '0;
               end else if (tx_fire) begin
                  tx_idx_reg <= tx_idx_reg + 1'b1;
                  if (slot_last) begin
                     tx_have_reg  <= 1'b0;
                     tx_slots_reg <= frame_last ? 8'h00 : tx_slots_reg + 8'h01;
                     if (frame_last) begin
                        tx_st_reg <= CGSW_TX_GAP;
                     end
                  end
               end
            end
            CGSW_TX_GAP: begin
               if (tx_fire) begin
                  tx_gap_reg <= gap_last ? 4'h0 : tx_gap_reg + 4'h1;
                  if (gap_last) begin
                     tx_st_reg <= CGSW_TX_SEND;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive code groups: gap strip, slot sync and packing
   cgsw_sync_e          sy_st_reg;
   logic [SLOT_W-1:0]   rx_acc_reg;
   logic [IDX_W-1:0]    rx_idx_reg;

   // gap groups never reach the packer
   wire rx_take  = slot_codegroup_valid_in && (slot_codegroup_data_in != GAP_GROUP);
   wire rx_fill  = slot_codegroup_data_in == FILL_GROUP;
   wire rx_slip  = rx_fill && (rx_idx_reg != '0);
   // loss flag mirrors the loss state
   assign slot_sync_lost_out = sy_st_reg == CGSW_SYNC_LOSS;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sy_st_reg         <= CGSW_SYNC_LOSS;
         rx_acc_reg        <= '0;
         rx_idx_reg        <= '0;
         rx_slot_word_out  <= '0;
         rx_slot_valid_out <= 1'b0;
      end else begin
         rx_slot_valid_out <= 1'b0;
         unique case (sy_st_reg)
            CGSW_SYNC_LOSS: begin
               // fill group restarts the grouping as loss falls
               if (rx_take && rx_fill) begin
                  sy_st_reg                <= CGSW_SYNC_HELD;
                  rx_acc_reg[SG_W-1:0]     <= slot_codegroup_data_in;
                  rx_idx_reg               <= IDX_AFTER_FILL;
               end
            end
            CGSW_SYNC_HELD: begin
               if (rx_take && rx_slip) begin
                  sy_st_reg  <= CGSW_SYNC_LOSS;
                  rx_idx_reg <= '0;
               end else if (rx_take) begin
                  // eight groups fill one slot word
                  rx_acc_reg[rx_idx_reg*SG_W +: SG_W] <= slot_codegroup_data_in;
                  rx_idx_reg <= rx_idx_reg + 1'b1;
                  if (rx_idx_reg == IDX_LAST) begin
                     rx_slot_word_out  <= {slot_codegroup_data_in,
                                           rx_acc_reg[SLOT_W-SG_W-1:0]};
                     rx_slot_valid_out <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame start smoothing: local flywheel nudged one cycle per frame
   localparam logic [FS_W-1:0] FS_NOM  = FS_W'(FRAME_PERIOD_CYCLES - 1);
   localparam logic [FS_W-1:0] FS_LONG = FS_W'(FRAME_PERIOD_CYCLES);
   localparam logic [FS_W-1:0] FS_SHRT = FS_W'(FRAME_PERIOD_CYCLES - 2);
   localparam logic [FS_W-1:0] FS_HALF = FS_W'(FRAME_PERIOD_CYCLES / 2);

   logic            fs_q1_reg, fs_q2_reg, fs_q3_reg;
   logic [FS_W-1:0] fs_cnt_reg, fs_lim_reg;

   wire fs_edge = fs_q2_reg && !fs_q3_reg;
   wire fs_wrap = fs_cnt_reg >= fs_lim_reg;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         fs_q1_reg                <= 1'b0;
         fs_q2_reg                <= 1'b0;
         fs_q3_reg                <= 1'b0;
         fs_cnt_reg               <= '0;
         fs_lim_reg               <= FS_NOM;
         smoothed_frame_start_out <= 1'b0;
      end else begin
         fs_q1_reg <= incoming_frame_start_in;
         fs_q2_reg <= fs_q1_reg;
         fs_q3_reg <= fs_q2_reg;
         fs_cnt_reg <= fs_wrap ? '0 : fs_cnt_reg + 1'b1;
         smoothed_frame_start_out <= fs_wrap;
         // phase error corrected by at most one cycle per frame
         if (fs_edge) begin
            if (fs_cnt_reg == '0) begin
               fs_lim_reg <= FS_NOM;
            end else if (fs_cnt_reg < FS_HALF) begin
               fs_lim_reg <= FS_LONG;
            end else begin
               fs_lim_reg <= FS_SHRT;
            end
         end else if (fs_wrap) begin
            fs_lim_reg <= FS_NOM;
         end
      end
   end
endmodule

// ==== tb/cgsw_adapter_props.sv ====
// checker for cgsw_adapter, bound to its ports
// assumes reset_in clears both clock domains
module cgsw_adapter_props
   import cgsw_pkg::*;
#(
   parameter int FRAME_PERIOD_CYCLES = 40
) (
   input wire logic              clk_in,
   input wire logic              reset_in,
   input wire logic              recovered_clock_in,
   input wire logic              serial_line_bits_in,
   input wire logic              frame_start_flag_out,
   input wire logic [SLOT_W-1:0] tx_slot_word_in,
   input wire logic              tx_slot_valid_in,
   input wire logic              tx_slot_ready_out,
   input wire logic [SG_W-1:0]   slot_codegroup_data_out,
   input wire logic              slot_codegroup_valid_out,
   input wire logic              slot_codegroup_ready_in,
   input wire logic [SG_W-1:0]   slot_codegroup_data_in,
   input wire logic              slot_codegroup_valid_in,
   input wire logic              rx_slot_valid_out,
   input wire logic              slot_sync_lost_out,
   input wire logic              smoothed_frame_start_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0]  hist_reg;
   logic [15:0] gap_reg;
   always_ff @(posedge recovered_clock_in or posedge reset_in) begin
      if (reset_in) hist_reg <= 9'h000;
      else hist_reg <= {hist_reg[7:0], serial_line_bits_in};
   end
   // cycles since last smoothed frame start
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) gap_reg <= 16'hffff;
      else if (smoothed_frame_start_out) gap_reg <= 16'h0000;
      else if (gap_reg != 16'hffff) gap_reg <= gap_reg + 16'h0001;
   end
   ////////////////////////////////////////////////////////////////////////////////
   comma_flag_a: assert property (@(posedge recovered_clock_in) disable iff (reset_in)
      frame_start_flag_out |-> hist_reg[6:0] == COMMA_SEQ || hist_reg[7:1] == COMMA_SEQ
         || hist_reg[8:2] == COMMA_SEQ) else $error("flag without comma");
   flag_pulse_a: assert property (@(posedge recovered_clock_in) disable iff (reset_in)
      frame_start_flag_out |=> !frame_start_flag_out) else $error("flag too long");
   loss_exit_a: assert property (@(posedge clk_in) disable iff (reset_in)
      slot_sync_lost_out && slot_codegroup_valid_in && slot_codegroup_data_in == FILL_GROUP
      |=> !slot_sync_lost_out) else $error("loss not left on fill");
   rx_word_cause_a: assert property (@(posedge clk_in) disable iff (reset_in)
      rx_slot_valid_out |-> $past(slot_codegroup_valid_in) && !$past(slot_sync_lost_out)
         ##1 !rx_slot_valid_out) else $error("rx word without group");
   tx_answer_a: assert property (@(posedge clk_in) disable iff (reset_in)
      tx_slot_valid_in && tx_slot_ready_out |=> slot_codegroup_valid_out
         && slot_codegroup_data_out == $past(tx_slot_word_in[8:0])) else $error("no group0");
   tx_stall_a: assert property (@(posedge clk_in) disable iff (reset_in)
      slot_codegroup_valid_out |-> !tx_slot_ready_out) else $error("ready while sending");
   tx_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
      slot_codegroup_valid_out && !slot_codegroup_ready_in |=> slot_codegroup_valid_out
         && $stable(slot_codegroup_data_out)) else $error("group changed in stall");
   fs_period_a: assert property (@(posedge clk_in) disable iff (reset_in)
      smoothed_frame_start_out && gap_reg != 16'hffff |-> gap_reg >= FRAME_PERIOD_CYCLES - 2
         && gap_reg <= FRAME_PERIOD_CYCLES) else $error("frame period off");
endmodule
bind cgsw_adapter cgsw_adapter_props #(.FRAME_PERIOD_CYCLES(FRAME_PERIOD_CYCLES)) props (.*);

// ==== tb/cgsw_line_model.sv ====
// line partner: link clock, loopback of tx bits, tx group decoder
// assumes the adapter sends idle groups between data
module cgsw_line_model
   import cgsw_pkg::*;
(
   output logic       link_clk_out,
   input  wire logic  reset_in,
   input  wire logic  line_in,
   output logic       line_out,
   output logic [9:0] group_out,
   output logic       group_valid_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] hunt_reg;
   logic [3:0] cnt_reg;
   logic       lock_reg;
   initial begin
      link_clk_out = 1'b0;
      #7.3;
      forever #15 link_clk_out = ~link_clk_out;
   end
   always @(negedge link_clk_out) line_out <= line_in;
   // msb first, comma framing
   // decoder samples mid-bit, away from the launching edge
   always @(negedge link_clk_out or posedge reset_in) begin
      if (reset_in) begin
         lock_reg <= 1'b0;
         cnt_reg <= 4'h0;
         hunt_reg <= 10'h000;
         group_valid_out <= 1'b0;
      end else begin
         hunt_reg <= {hunt_reg[8:0], line_in};
         group_valid_out <= 1'b0;
         if (!lock_reg && {hunt_reg[5:0], line_in} == COMMA_SEQ) begin
            lock_reg <= 1'b1;
            cnt_reg <= COMMA_NEXT;
         end else if (cnt_reg == CG_LAST) begin
            cnt_reg <= 4'h0;
            group_out <= {hunt_reg[8:0], line_in};
            group_valid_out <= lock_reg;
         end else cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule

// ==== tb/test_cgsw_adapter.sv ====
// testbench for cgsw_adapter with line loopback and slot loopback
// assumes the line model loops tx bits back to rx
module test_cgsw_adapter;
   timeunit 1ns;
   timeprecision 1ps;
   import cgsw_pkg::*;
   localparam int P = 40;
   logic clk_in = 0, reset_in = 1, link_clk, line_rx, line_tx, en = 0, flag, cg_rdy, cg_ov;
   logic cg_v = 0, ts_v = 0, ts_rdy, sg_ov, sg_rdy = 1, sg_v = 0, rs_v, lost, fs_in = 0, fs_out;
   logic inj_v = 0, lb_v = 0, stall = 0, arm = 0, rx_b = 0, fs_on = 0, m_v, rdy_now;
   logic [9:0] cg_d = 0, cg_o, m_d;
   logic [8:0] sg_o, sg_d = 0, inj_d, lb_d;
   logic [71:0] ts_d = 0, rs_o, e;
   logic [71:0] q_line[$], q_cg[$], q_slot[$];
   int seed = 79, checks = 0, num_errors = 0, flags = 0, gaps = 0, fi = 0, fo = 0;
   always #10 clk_in = ~clk_in;
   cgsw_line_model LM (.link_clk_out(link_clk), .reset_in(reset_in), .line_in(line_tx),
      .line_out(line_rx), .group_out(m_d), .group_valid_out(m_v));
   cgsw_adapter #(.FRAME_PERIOD_CYCLES(P)) DUT (.clk_in(clk_in), .reset_in(reset_in),
      .recovered_clock_in(link_clk), .serial_line_bits_in(line_rx),
      .serial_line_bits_out(line_tx), .frame_align_enable_in(en), .frame_start_flag_out(flag),
      .codegroup_parallel_data_in(cg_d), .codegroup_parallel_valid_in(cg_v),
      .codegroup_parallel_ready_out(cg_rdy), .codegroup_parallel_data_out(cg_o),
      .codegroup_parallel_valid_out(cg_ov), .tx_slot_word_in(ts_d), .tx_slot_valid_in(ts_v),
      .tx_slot_ready_out(ts_rdy), .slot_codegroup_data_out(sg_o),
      .slot_codegroup_valid_out(sg_ov), .slot_codegroup_ready_in(sg_rdy),
      .slot_codegroup_data_in(sg_d), .slot_codegroup_valid_in(sg_v), .rx_slot_word_out(rs_o),
      .rx_slot_valid_out(rs_v), .slot_sync_lost_out(lost), .incoming_frame_start_in(fs_in),
      .smoothed_frame_start_out(fs_out));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [71:0] x, input logic [71:0] g);
      checks++;
      if (x !== g) begin
         num_errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, x, g);
      end
   endtask
   task give_verdict;
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic send_cg(input logic [9:0] d, input logic to_rx);
      int n;
      cg_d = d;
      cg_v = 1;
      q_line.push_back(d);
      if (to_rx) q_cg.push_back(d);
      for (n = 0; cg_rdy !== 1'b1 && n < 2000; n++) @(negedge clk_in);
      @(negedge clk_in);
   endtask
   task automatic send_slot(input logic to_rx);
      int n, k;
      ts_d[8:0] = FILL_GROUP;
      for (k = 1; k < 8; k++) ts_d[9*k +: 9] = $random(seed) & 9'h0ff;
      ts_v = 1;
      if (to_rx) q_slot.push_back(ts_d);
      for (n = 0; ts_rdy !== 1'b1 && n < 1000; n++) @(negedge clk_in);
      @(negedge clk_in);
   endtask
   task automatic inject(input logic [8:0] d);
      @(posedge clk_in);
      inj_v = 1;
      inj_d = d;
      @(posedge clk_in);
      inj_v = 0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge clk_in) begin
      rdy_now = stall ? ($random(seed) & 3) != 0 : 1'b1;
      sg_rdy <= rdy_now;
      sg_v <= inj_v | lb_v;
      sg_d <= inj_v ? inj_d : lb_d;
      // group that fires at the coming rising edge loops back one cycle later
      lb_v <= sg_ov === 1'b1 && rdy_now;
      lb_d <= sg_o;
      if (sg_ov === 1'b1 && rdy_now && sg_o === GAP_GROUP) gaps++;
      if (rs_v === 1'b1) begin
         e = q_slot.size() ? q_slot.pop_front() : 'x;
         chk(e, rs_o);
      end
      if (cg_ov === 1'b1 && cg_o !== TX_IDLE_CG) begin
         if (arm) begin
            e = q_cg.size() ? q_cg.pop_front() : 'x;
            chk(e, cg_o);
         end else if (rx_b && cg_o === 10'h3e0) arm = 1;
      end
      if (fs_on && fs_out === 1'b1) fo++;
   end
   always @(negedge link_clk) begin
      if (flag === 1'b1) flags++;
      if (m_v === 1'b1 && m_d !== TX_IDLE_CG) begin
         e = q_line.size() ? q_line.pop_front() : 'x;
         chk(e, m_d);
      end
   end
   initial begin
      #500000;
      num_errors++;
      give_verdict;
   end
   initial begin
      repeat (10) @(posedge clk_in);
      @(negedge clk_in);
      reset_in = 0;
      fork
         begin
            fs_on = 1;
            repeat (15) begin
               fs_in = 1;
               fi++;
               repeat (4) @(negedge clk_in);
               fs_in = 0;
               repeat (P - 4 + ($random(seed) & 1)) @(negedge clk_in);
            end
            fs_on = 0;
         end
      join_none
      send_cg(10'h3e0, 0);
      repeat (8) send_cg($random(seed) & 10'h1bb, 0);
      cg_v = 0;
      repeat (400) @(negedge clk_in);
      chk(0, flags);
      en = 1;
      repeat (20) @(negedge clk_in);
      rx_b = 1;
      send_cg(10'h3e0, 0);
      repeat (24) send_cg($random(seed) & 10'h1bb, 1);
      cg_v = 0;
      repeat (1500) @(negedge clk_in);
      chk(1, flags);
      chk(0, q_line.size() + q_cg.size());
      chk(1, fo - fi <= 1 && fi - fo <= 1);
      stall = 1;
      repeat (32) send_slot(1);
      ts_v = 0;
      repeat (300) @(negedge clk_in);
      chk(4, gaps);
      inject(FILL_GROUP);
      inject(9'h005);
      inject(9'h006);
      inject(FILL_GROUP);
      repeat (3) @(negedge clk_in);
      chk(1, lost);
      repeat (2) send_slot(1);
      ts_v = 0;
      repeat (100) @(negedge clk_in);
      chk(0, lost);
      chk(0, q_slot.size());
      give_verdict;
   end
endmodule
